// ### cocl_map.svh
// Option loader constants: flash addresses, SFR read addresses, bit positions
// Assumes a 16-bit flash read port and a byte-addressed SFR read port
//
// Function
// - After every system reset, fetch all option words and apply them first.
// - Option SFRs read back only while the init status flag is zero.
// - Erased option words read 0xFFFF, giving every default.
// - Option words one and two read at 0xF922 and 0xF924, byte or word.
// - Word zero bit 7 enables low-speed clock one backup, default on.
// - Word zero bit 0 is master watchdog enable, default run.
// - With master on, bit 2 keeps watchdog running in halt states.
// - With master on, bit 3 keeps watchdog running in deep halt.
// - Two-bit PLL reference select picks 24, 16 or 1 MHz.
// - Wait select 01 is wait, 11 no-wait; 00 and 10 are forbidden.
// - Word two bit 15 zero builds remap reset value, one forces 0x00.
// - Word two bits 14..12 give remap segment bits reset value.
// - Word two bits 11..8 give remap upper address bits reset value.
// - Word zero bit 8 zero enables remap, one disables it.
// - After CPU reset start at 0x0000, or remap register when remap on.
// - After system reset start at 0x0000, or remap reset value when on.
// - With remap on, the preset remap is reapplied at every system reset.
// - Option words sit at 0x3:FFD0, 0x3:FFD2, 0x3:FFD4 for largest memory.
`ifndef COCL_MAP_SVH
`define COCL_MAP_SVH

// Flash word addresses of the option area (largest memory, byte address)
`define COCL_FLASH_OPT0      20'h3FFD0
`define COCL_FLASH_OPT1      20'h3FFD2
`define COCL_FLASH_OPT2      20'h3FFD4
// SFR read addresses
`define COCL_SFR_OPT0        16'hF920
`define COCL_SFR_OPT1        16'hF922
`define COCL_SFR_OPT2        16'hF924
// Blank flash value
`define COCL_ERASED          16'hFFFF
// Word zero fields
`define COCL_B_WDT_MASTER    0
`define COCL_B_WDT_HALT      2
`define COCL_B_WDT_DEEP      3
`define COCL_B_BACKUP        7
`define COCL_B_REMAP_EN      8
// Word one fields
`define COCL_B_PLL_LO        2
`define COCL_B_CPU_LO        0
// Word two fields
`define COCL_B_PRESET_SEL    15
`define COCL_B_SEG_LO        12
`define COCL_B_ADR_LO        8
// Start address when remap is off, and forced remap reset value
`define COCL_START_DEFAULT   8'h00
`define COCL_REMAP_FORCED    8'h00

`endif

// ### cocl_pkg.sv
// Types shared by the option loader
// Assumes cocl_map.svh supplies the numeric constants
package cocl_pkg;
    typedef logic [15:0] cocl_word_t;
    typedef logic [7:0]  cocl_remap_t;
    typedef enum logic [1:0] {
        COCL_PLL_1M  = 2'h0,
        COCL_PLL_16M = 2'h1,
        COCL_PLL_24M = 2'h2
    } cocl_pll_e;
endpackage : cocl_pkg

// ### cocl_decode.sv
// Decoder from the three option words to settings
// Assumes words are stable once the loader reports done
`timescale 1ns/1ps
`default_nettype none
`include "cocl_map.svh"
module cocl_decode
    import cocl_pkg::*;
(
    // Captured option words
    input  wire cocl_word_t  opt0,
    input  wire cocl_word_t  opt2,
    input  wire cocl_word_t  opt1,
    // Decoded settings
    output logic             wdt_run,
    output logic             wdt_halt_run,
    output logic             wdt_deep_run,
    output logic             backup_en,
    output logic             remap_en,
    output cocl_remap_t      remap_reset_val,
    output cocl_pll_e        pll_sel,
    output logic             cpu_wait,
    output logic             cpu_wait_illegal
);
    logic [1:0] pll_code;
    logic [1:0] cpu_code;

    // Watchdog state gates only apply when the master enable is on
    assign wdt_run      = opt0[`COCL_B_WDT_MASTER];
    assign wdt_halt_run = opt0[`COCL_B_WDT_MASTER] & opt0[`COCL_B_WDT_HALT];
    assign wdt_deep_run = opt0[`COCL_B_WDT_MASTER] & opt0[`COCL_B_WDT_DEEP];
    assign backup_en    = opt0[`COCL_B_BACKUP];
    assign remap_en     = ~opt0[`COCL_B_REMAP_EN];

    // Remap reset value: segment in 6..4, upper address in 3..0, bit 7 zero
    assign remap_reset_val = opt2[`COCL_B_PRESET_SEL] ? `COCL_REMAP_FORCED :
        {1'b0, opt2[`COCL_B_SEG_LO +: 3], opt2[`COCL_B_ADR_LO +: 4]};

    // PLL code 11 is the erased default (24 MHz); 10 is 16 MHz, others 1 MHz
    assign pll_code = opt1[`COCL_B_PLL_LO +: 2];
    always_comb begin
        unique case (pll_code)
            2'h3:    pll_sel = COCL_PLL_24M;
            2'h2:    pll_sel = COCL_PLL_16M;
            default: pll_sel = COCL_PLL_1M;
        endcase
    end

    // Forbidden codes fall back to the matching legal mode and are flagged
    assign cpu_code         = opt1[`COCL_B_CPU_LO +: 2];
    assign cpu_wait         = ~cpu_code[1];
    assign cpu_wait_illegal = ~cpu_code[0];
endmodule : cocl_decode
`default_nettype wire

// ### cocl_loader.sv
// Option loader top: reads three option words from flash after system reset,
// decodes them, holds the CPU in reset until done, serves SFR reads
// Assumes a flash read port answering with a one-cycle valid pulse
// All outputs are registered; the settings settle once per system reset
`timescale 1ns/1ps
`default_nettype none
`include "cocl_map.svh"
module cocl_loader
    import cocl_pkg::*;
(
    // Clock and system reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // CPU reset request (break instruction), one-cycle pulse
    input  wire logic        CPU_RST_REQ,
    // Flash read port
    output logic             FLASH_REQ,
    output logic [19:0]      FLASH_ADDR,
    input  wire logic        FLASH_VALID,
    input  wire cocl_word_t  FLASH_DATA,
    // SFR read port
    input  wire logic        SFR_RD,
    input  wire logic [15:0] SFR_ADDR,
    input  wire logic        SFR_BYTE,
    output logic [15:0]      SFR_RDATA,
    output logic             SFR_HIT,
    // Remap register state kept by the flash controller
    input  wire cocl_remap_t REMAP_ADDR_NOW,
    // Initialisation flag, high while loading
    output logic             INIT_STATUS_FLAG,
    // CPU release and start address
    output logic             CPU_RUN,
    output logic [7:0]       CPU_START,
    // Decoded settings
    output logic             WATCHDOG_MASTER_ENABLE,
    output logic             WATCHDOG_HALT_ENABLE,
    output logic             WATCHDOG_DEEP_HALT_ENABLE,
    output logic             SLOW_CLOCK_BACKUP_ENABLE,
    output logic             REMAP_ENABLE_OPTION,
    output cocl_remap_t      REMAP_RESET_VALUE,
    output cocl_pll_e        PLL_REFERENCE_SELECT,
    output logic             CPU_WAIT_SELECT,
    output logic             CPU_WAIT_ILLEGAL
);
    // Load sequence: one request per word, each waiting for its own answer,
    // so a slow flash can never hand a word to the wrong holding register
    typedef enum logic [2:0] {
        COCL_S_REQ0,
        COCL_S_WAIT0,
        COCL_S_REQ1,
        COCL_S_WAIT1,
        COCL_S_REQ2,
        COCL_S_WAIT2,
        COCL_S_DONE
    } cocl_state_e;

    cocl_state_e state_r;
    // Captured words and break marker
    cocl_word_t  opt0_r;
    cocl_word_t  opt1_r;
    cocl_word_t  opt2_r;
    logic        cpu_rst_r;
    // Decoder outputs, sampled when the load completes; remap_en and remap_reset_val also feed the start address every cycle
    logic        wdt_run;
    logic        wdt_halt_run;
    logic        wdt_deep_run;
    logic        backup_en;
    logic        remap_en;
    cocl_remap_t remap_reset_val;
    cocl_pll_e   pll_sel;
    logic        cpu_wait;
    logic        cpu_wait_illegal;
    // Combinational read mux
    logic [15:0] rd_word;
    logic        rd_hit;

    // Fetch sequencer: restarts from word zero on every system reset
    // A reset in mid-load throws away any words already captured
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= COCL_S_REQ0;
        end else begin
            unique case (state_r)
                COCL_S_REQ0:  state_r <= COCL_S_WAIT0;
                COCL_S_WAIT0: if (FLASH_VALID) state_r <= COCL_S_REQ1;
                COCL_S_REQ1:  state_r <= COCL_S_WAIT1;
                COCL_S_WAIT1: if (FLASH_VALID) state_r <= COCL_S_REQ2;
                COCL_S_REQ2:  state_r <= COCL_S_WAIT2;
                COCL_S_WAIT2: if (FLASH_VALID) state_r <= COCL_S_DONE;
                COCL_S_DONE:  state_r <= COCL_S_DONE;
                default:      state_r <= COCL_S_REQ0;   // Unused code restarts the load
            endcase
        end
    end

    // Flash request pulse and word address, always whole-word reads
    // The address stands from one request to the next while the flash works
    // Bytes are never fetched alone, so a word is always read in one piece
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FLASH_REQ  <= 1'b0;
            FLASH_ADDR <= `COCL_FLASH_OPT0;
        end else begin
            FLASH_REQ <= (state_r == COCL_S_REQ0) || (state_r == COCL_S_REQ1) ||
                         (state_r == COCL_S_REQ2);
            unique case (state_r)
                COCL_S_REQ1: FLASH_ADDR <= `COCL_FLASH_OPT1;
                COCL_S_REQ2: FLASH_ADDR <= `COCL_FLASH_OPT2;
                COCL_S_REQ0: FLASH_ADDR <= `COCL_FLASH_OPT0;
                default:     FLASH_ADDR <= FLASH_ADDR;
            endcase
        end
    end

    // Holding registers start erased so defaults apply until overwritten
    // Capture is keyed to the wait state, so an answer outside one is dropped
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            opt0_r <= `COCL_ERASED;
            opt1_r <= `COCL_ERASED;
            opt2_r <= `COCL_ERASED;
        end else if (FLASH_VALID) begin
            if (state_r == COCL_S_WAIT0) opt0_r <= FLASH_DATA;
            if (state_r == COCL_S_WAIT1) opt1_r <= FLASH_DATA;
            if (state_r == COCL_S_WAIT2) opt2_r <= FLASH_DATA;
        end
    end

    // Pure decode; its outputs register on completion, and remap_en and remap_reset_val drive the start address every cycle
    cocl_decode u_decode (
        .opt0             (opt0_r),
        .opt2             (opt2_r),
        .opt1             (opt1_r),
        .wdt_run          (wdt_run),
        .wdt_halt_run     (wdt_halt_run),
        .wdt_deep_run     (wdt_deep_run),
        .backup_en        (backup_en),
        .remap_en         (remap_en),
        .remap_reset_val  (remap_reset_val),
        .pll_sel          (pll_sel),
        .cpu_wait         (cpu_wait),
        .cpu_wait_illegal (cpu_wait_illegal)
    );

    // Settings register only on completion, so nothing half-loaded leaks out
    // Reset values match an erased part, so a stalled load still looks blank
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            WATCHDOG_MASTER_ENABLE    <= 1'b1;
            WATCHDOG_HALT_ENABLE      <= 1'b1;
            WATCHDOG_DEEP_HALT_ENABLE <= 1'b1;
            SLOW_CLOCK_BACKUP_ENABLE  <= 1'b1;
            REMAP_ENABLE_OPTION       <= 1'b0;
            REMAP_RESET_VALUE         <= `COCL_REMAP_FORCED;
            PLL_REFERENCE_SELECT      <= COCL_PLL_24M;
            CPU_WAIT_SELECT           <= 1'b0;
            CPU_WAIT_ILLEGAL          <= 1'b0;
            INIT_STATUS_FLAG          <= 1'b1;
            CPU_RUN                   <= 1'b0;
        end else if (state_r == COCL_S_DONE && !CPU_RUN) begin
            WATCHDOG_MASTER_ENABLE    <= wdt_run;
            WATCHDOG_HALT_ENABLE      <= wdt_halt_run;
            WATCHDOG_DEEP_HALT_ENABLE <= wdt_deep_run;
            SLOW_CLOCK_BACKUP_ENABLE  <= backup_en;
            REMAP_ENABLE_OPTION       <= remap_en;
            REMAP_RESET_VALUE         <= remap_reset_val;
            PLL_REFERENCE_SELECT      <= pll_sel;
            CPU_WAIT_SELECT           <= cpu_wait;
            CPU_WAIT_ILLEGAL          <= cpu_wait_illegal;
            INIT_STATUS_FLAG          <= 1'b0;
            CPU_RUN                   <= 1'b1;
        end
    end

    // Remember a CPU reset so the next start address uses the live register
    // The request comes from logic on this clock, so it needs no synchroniser
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cpu_rst_r <= 1'b0;
        end else if (CPU_RST_REQ) begin
            cpu_rst_r <= 1'b1;
        end
    end

    // Start address: system reset uses preset, CPU reset uses current register
    // Limitation: the break marker stays set until the next system reset, so
    // every later start after a break follows the live remap register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CPU_START <= `COCL_START_DEFAULT;
        end else if (!remap_en) begin
            CPU_START <= `COCL_START_DEFAULT;
        end else if (cpu_rst_r || CPU_RST_REQ) begin
            CPU_START <= REMAP_ADDR_NOW;
        end else begin
            CPU_START <= remap_reset_val;
        end
    end

    // SFR decode; high byte alone reads at odd address, low bits on the bus
    // Word zero also answers at its own address, which costs one more mux leg
    always_comb begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        unique case ({SFR_ADDR[15:1], 1'b0})
            `COCL_SFR_OPT0: rd_word = opt0_r;
            `COCL_SFR_OPT1: rd_word = opt1_r;
            `COCL_SFR_OPT2: rd_word = opt2_r;
            default:        rd_hit  = 1'b0;
        endcase
        if (SFR_BYTE) begin
            rd_word = SFR_ADDR[0] ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};
        end else if (SFR_ADDR[0]) begin
            rd_hit  = 1'b0;   // Word access must be even
            rd_word = 16'h0000;
        end
    end

    // Read data registered; zero while the init flag is set
    // Reading while loading returns zero rather than a half-loaded word;
    // the hit flag still reports the decode so software can tell the two apart
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SFR_RDATA <= 16'h0000;
            SFR_HIT   <= 1'b0;
        end else begin
            SFR_HIT   <= SFR_RD && rd_hit;
            if (SFR_RD && rd_hit && !INIT_STATUS_FLAG) begin
                SFR_RDATA <= rd_word;
            end else begin
                SFR_RDATA <= 16'h0000;
            end
        end
    end
endmodule : cocl_loader
`default_nettype wire

// ### cocl_loader_sva.sv
// Checker for the option loader: load order, decode and read-back properties
// Assumes it is bound to cocl_loader and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cocl_loader_sva
    import cocl_pkg::*;
(
    // Clock, resets
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        CPU_RST_REQ,
    // Flash port
    input wire logic        FLASH_REQ,
    input wire logic [19:0] FLASH_ADDR,
    input wire logic        FLASH_VALID,
    input wire cocl_word_t  FLASH_DATA,
    // SFR port
    input wire logic        SFR_RD,
    input wire logic [15:0] SFR_ADDR,
    input wire logic [15:0] SFR_RDATA,
    input wire logic        SFR_HIT,
    // Status and settings
    input wire cocl_remap_t REMAP_ADDR_NOW,
    input wire logic        INIT_STATUS_FLAG,
    input wire logic        CPU_RUN,
    input wire logic [7:0]  CPU_START,
    input wire logic        WATCHDOG_MASTER_ENABLE,
    input wire logic        WATCHDOG_HALT_ENABLE,
    input wire logic        WATCHDOG_DEEP_HALT_ENABLE,
    input wire logic        SLOW_CLOCK_BACKUP_ENABLE,
    input wire logic        REMAP_ENABLE_OPTION,
    input wire cocl_remap_t REMAP_RESET_VALUE,
    input wire cocl_pll_e   PLL_REFERENCE_SELECT,
    input wire logic        CPU_WAIT_SELECT,
    input wire logic        CPU_WAIT_ILLEGAL
);
    logic [1:0] vcnt_r;
    logic       brk_r;
    cocl_word_t w_r [3];
    default clocking dck @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Own copy of the delivered words, so decode checks need no internals
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            vcnt_r <= 2'h0;
            brk_r  <= 1'b0;
        end else begin
            brk_r <= brk_r | CPU_RST_REQ;
            if (FLASH_VALID && vcnt_r != 2'h3) begin
                w_r[vcnt_r] <= FLASH_DATA;
                vcnt_r      <= vcnt_r + 2'h1;
            end
        end
    end
    a_flash_order: assert property (FLASH_REQ |-> FLASH_ADDR == 20'h3FFD0 + {17'h0, vcnt_r, 1'b0})
        else $error("flash word read out of order");
    a_load_done: assert property (FLASH_VALID && vcnt_r == 2'h2
        |-> ##[1:3] CPU_RUN && !INIT_STATUS_FLAG) else $error("loader did not release the cpu");
    a_run_gate: assert property (CPU_RUN |-> vcnt_r == 2'h3 && !INIT_STATUS_FLAG)
        else $error("cpu released before all words arrived");
    a_sfr_block: assert property (SFR_RD && INIT_STATUS_FLAG |=> SFR_RDATA == 16'h0000)
        else $error("option data visible while loading");
    a_sfr_unmap: assert property (SFR_RD && (SFR_ADDR < 16'hF920 || SFR_ADDR > 16'hF925)
        |=> !SFR_HIT && SFR_RDATA == 16'h0000) else $error("unmapped read answered");
    a_wdt_decode: assert property (CPU_RUN |-> WATCHDOG_MASTER_ENABLE == w_r[0][0]
        && (!w_r[0][0] || {WATCHDOG_DEEP_HALT_ENABLE, WATCHDOG_HALT_ENABLE} == w_r[0][3:2]))
        else $error("watchdog decode wrong");
    a_misc_decode: assert property (CPU_RUN |-> SLOW_CLOCK_BACKUP_ENABLE == w_r[0][7]
        && REMAP_ENABLE_OPTION == !w_r[0][8] && CPU_WAIT_SELECT == !w_r[1][1]
        && CPU_WAIT_ILLEGAL == !w_r[1][0] && PLL_REFERENCE_SELECT == (w_r[1][3:2] == 2'h3 ?
        COCL_PLL_24M : w_r[1][3:2] == 2'h2 ? COCL_PLL_16M : COCL_PLL_1M)) else $error("mode decode wrong");
    a_remap_preset: assert property (CPU_RUN |-> REMAP_RESET_VALUE ==
        (w_r[2][15] ? 8'h00 : {1'b0, w_r[2][14:8]})) else $error("remap preset wrong");
    a_sys_start: assert property ($rose(CPU_RUN) |=> CPU_START ==
        (REMAP_ENABLE_OPTION ? REMAP_RESET_VALUE : 8'h00)) else $error("start address after reset");
    a_brk_start: assert property (CPU_RUN && $past(brk_r, 2) |-> CPU_START ==
        (REMAP_ENABLE_OPTION ? REMAP_ADDR_NOW : 8'h00)) else $error("start address after break");
    // Remap, PLL, wait-select and watchdog master settings must not move while the cpu runs
    a_hold_set: assert property (CPU_RUN && $past(CPU_RUN) |-> $stable({REMAP_RESET_VALUE,
        PLL_REFERENCE_SELECT, CPU_WAIT_SELECT, WATCHDOG_MASTER_ENABLE, REMAP_ENABLE_OPTION}))
        else $error("settings changed while running");
endmodule : cocl_loader_sva
bind cocl_loader cocl_loader_sva u_sva (.*);
`default_nettype wire

// ### cocl_flash_model.sv
// Flash option area model answering whole-word reads after a set latency
// Assumes one outstanding request at a time, as the loader issues them
`timescale 1ns/1ps
`default_nettype none
module cocl_flash_model
    import cocl_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Read port
    input  wire logic        FLASH_REQ,
    input  wire logic [19:0] FLASH_ADDR,
    output logic             FLASH_VALID,
    output cocl_word_t       FLASH_DATA,
    // Programmed contents and answer delay
    input  wire cocl_word_t  WORD0,
    input  wire cocl_word_t  WORD1,
    input  wire cocl_word_t  WORD2,
    input  wire logic [3:0]  LATENCY
);
    logic [3:0]  wait_r;
    logic        busy_r;
    logic [19:0] addr_r;
    // Data toggles when idle so a stale word never passes for an answer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            busy_r      <= 1'b0;
            wait_r      <= 4'h0;
            addr_r      <= 20'h00000;
            FLASH_VALID <= 1'b0;
            FLASH_DATA  <= 16'h0000;
        end else begin
            FLASH_VALID <= 1'b0;
            FLASH_DATA  <= ~FLASH_DATA;
            if (FLASH_REQ) begin
                busy_r <= 1'b1;
                wait_r <= LATENCY;
                addr_r <= FLASH_ADDR;
            end else if (busy_r && wait_r > 4'h1) begin
                wait_r <= wait_r - 4'h1;
            end else if (busy_r) begin
                busy_r      <= 1'b0;
                FLASH_VALID <= 1'b1;
                case (addr_r)
                    20'h3FFD0: FLASH_DATA <= WORD0;
                    20'h3FFD2: FLASH_DATA <= WORD1;
                    20'h3FFD4: FLASH_DATA <= WORD2;
                    default:   FLASH_DATA <= 16'hFFFF;
                endcase
            end
        end
    end
endmodule : cocl_flash_model
`default_nettype wire

// ### test_code_option_config_loader.sv
// Self-checking bench for the option loader with a flash model on its far side
// Assumes the checker binds itself to cocl_loader
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_code_option_config_loader;
    import cocl_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, brk = 1'b0, rd_en = 1'b0, rd_byte = 1'b0;
    logic [15:0] rd_addr = 16'h0000, rdata;
    cocl_word_t w0 = 16'hFFFF, w1 = 16'hFFFF, w2 = 16'hFFFF, fdata;
    cocl_remap_t now_v = 8'h33, rrst;
    logic [3:0] lat = 4'h1;
    logic [19:0] faddr;
    logic [7:0] start;
    logic freq, fvalid, hit, init, run, wm, wh, wd, bk, ren, cw, cbad;
    cocl_pll_e pll;
    int failures = 0, n_checks = 0;
    // 50 MHz system clock
    always #10 clk = ~clk;
    cocl_loader DUT (.CLK(clk), .NRST(nrst), .CPU_RST_REQ(brk), .FLASH_REQ(freq),
        .FLASH_ADDR(faddr), .FLASH_VALID(fvalid), .FLASH_DATA(fdata), .SFR_RD(rd_en),
        .SFR_ADDR(rd_addr), .SFR_BYTE(rd_byte), .SFR_RDATA(rdata), .SFR_HIT(hit),
        .REMAP_ADDR_NOW(now_v), .INIT_STATUS_FLAG(init), .CPU_RUN(run), .CPU_START(start),
        .WATCHDOG_MASTER_ENABLE(wm), .WATCHDOG_HALT_ENABLE(wh), .WATCHDOG_DEEP_HALT_ENABLE(wd),
        .SLOW_CLOCK_BACKUP_ENABLE(bk), .REMAP_ENABLE_OPTION(ren), .REMAP_RESET_VALUE(rrst),
        .PLL_REFERENCE_SELECT(pll), .CPU_WAIT_SELECT(cw), .CPU_WAIT_ILLEGAL(cbad));
    cocl_flash_model u_flash (.CLK(clk), .NRST(nrst), .FLASH_REQ(freq), .FLASH_ADDR(faddr),
        .FLASH_VALID(fvalid), .FLASH_DATA(fdata), .WORD0(w0), .WORD1(w1), .WORD2(w2),
        .LATENCY(lat));
    task automatic close_out();
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // Program the option area, then pulse system reset for 6 cycles
    task automatic boot(input cocl_word_t a, b, c, input logic [3:0] l);
        w0 <= a; w1 <= b; w2 <= c; lat <= l; nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
    endtask : boot
    task automatic wait_run();
        int n;
        n = 0;
        while (run !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        if (n >= 300) begin failures++; close_out(); end
        @(posedge clk); // Start address settles on the release edge; wait one more edge
    endtask : wait_run
    task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] e, input logic h);
        rd_en <= 1'b1; rd_addr <= a; rd_byte <= b;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        `CK("sfr data", rdata, e)
        `CK("sfr hit", hit, h)
    endtask : rd
    task automatic brk_start(input logic [7:0] e);
        int n;
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        n = 0;
        while (start !== e && n < 8) begin @(posedge clk); n++; end
        `CK("break start", start, e)
    endtask : brk_start
    // Blank part: every setting except the remap preset checked at its default, data hidden while loading
    task automatic t_blank();
        boot(16'hFFFF, 16'hFFFF, 16'hFFFF, 4'h8);
        rd(16'hF920, 1'b0, 16'h0000, 1'b1);
        wait_run();
        `CK("wdt", {wm, wh, wd, bk}, 4'hF)
        `CK("remap", {ren, start}, 9'h000)
        `CK("pll", pll, COCL_PLL_24M)
        `CK("wait", {cw, cbad}, 2'b00)
        rd(16'hF922, 1'b0, 16'hFFFF, 1'b1);
        rd(16'hF926, 1'b0, 16'h0000, 1'b0);
    endtask : t_blank
    // Remap preset, reset again mid-load, slow flash, byte reads, break reset
    task automatic t_remap();
        boot(16'hFE72, 16'hFFF5, 16'h5AFF, 4'h5);
        repeat (3) @(posedge clk);
        boot(16'hFE72, 16'hFFF5, 16'h5AFF, 4'h5);
        wait_run();
        `CK("start", start, 8'h5A)
        `CK("preset", rrst, 8'h5A)
        `CK("flags", {ren, bk, wm}, 3'b100)
        `CK("mode", {pll, cw, cbad}, {COCL_PLL_1M, 2'b10})
        rd(16'hF925, 1'b1, 16'h005A, 1'b1);
        rd(16'hF922, 1'b1, 16'h00F5, 1'b1);
        rd(16'hF923, 1'b0, 16'h0000, 1'b0);
        brk_start(8'h33);
    endtask : t_remap
    // Every PLL and CPU mode code, remap preset forced, remap off
    task automatic t_codes();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            boot(16'hFFFB, {12'hFFF, c, c}, 16'hDAFF, 4'h2);
            wait_run();
            `CK("pll", pll, (c == 2'h3) ? COCL_PLL_24M : (c == 2'h2) ? COCL_PLL_16M : COCL_PLL_1M)
            `CK("cpu", {cw, cbad}, {~c[1], ~c[0]})
            `CK("wdt", {wm, wh, wd}, 3'b101)
            `CK("forced", rrst, 8'h00)
        end
        brk_start(8'h00);
    endtask : t_codes
    initial begin
        @(posedge clk);
        t_blank();
        t_remap();
        t_codes();
        close_out();
    end
endmodule : test_code_option_config_loader
`default_nettype wire
